// file: verif/pcfs_bus_agent.sv
`timescale 1ns/10ps
// ************************************************************
// far-side bus agent: event lines decoded from request kind; kinds 5 and 6 share one, kind 5 also drives master phase
// ************************************************************
module pcfs_bus_agent (
    input wire logic fire_i,
    input wire logic [2:0] kind_i,
    output logic addr_parity_err_o,
    output logic data_parity_err_o,
    output logic master_abort_o,
    output logic target_abort_rcvd_o,
    output logic target_abort_sent_o,
    output logic perr_seen_o,
    output logic master_phase_o
);
    // lines fall back to inactive as soon as the request is withdrawn
    always_comb begin
        addr_parity_err_o = fire_i && kind_i == 3'h0;
        data_parity_err_o = fire_i && kind_i == 3'h1;
        master_abort_o = fire_i && kind_i == 3'h2;
        target_abort_rcvd_o = fire_i && kind_i == 3'h3;
        target_abort_sent_o = fire_i && kind_i == 3'h4;
        perr_seen_o = fire_i && (kind_i == 3'h5 || kind_i == 3'h6); // any agent may pull the line
        master_phase_o = fire_i && kind_i == 3'h5; // kind 6: error while another agent masters
    end
endmodule

// file: verif/pci_function_command_status_test.sv
`timescale 1ns/10ps
module pci_function_command_status_test;
    logic ref_clk_i = 1'b0;
    logic resetn_i, ce_i, cfg_sel_i, cfg_wr_i, cfg_rd_i, fire, io_hit_i, mem_hit_i, special_cycle_i, master_req_i;
    logic [7:0] cfg_addr_i;
    logic [3:0] cfg_be_i;
    logic [2:0] kind;
    logic [31:0] cfg_wdata_i, cfg_rdata_o, r, d;
    logic cfg_rvalid_o, target_claim_o, master_req_o, serr_assert_o, perr_assert_o;
    logic ape, dpe, mab, tar, tas, pseen, mph;
    logic io_en, mem_en, mst_en, winv_en, par_en, syserr_drv;
    logic [1:0] devsel_timing_o;
    logic [3:0] master_cmd_o, be;
    logic [7:0] a;
    logic [15:0] cmd_m, st_m;
    integer seed = 32'h80ac;
    int errors = 0;
    int tests_run = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    pcfs_bus_agent i_pcfs_bus_agent (.fire_i(fire), .kind_i(kind), .addr_parity_err_o(ape),
        .data_parity_err_o(dpe), .master_abort_o(mab), .target_abort_rcvd_o(tar), .target_abort_sent_o(tas),
        .perr_seen_o(pseen), .master_phase_o(mph));

    pcfs_cmd_status i_pcfs_cmd_status (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .cfg_sel_i(cfg_sel_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
        .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .io_hit_i(io_hit_i), .mem_hit_i(mem_hit_i), .special_cycle_i(special_cycle_i),
        .target_claim_o(target_claim_o), .devsel_timing_o(devsel_timing_o), .master_req_i(master_req_i),
        .master_req_o(master_req_o), .master_cmd_o(master_cmd_o), .addr_parity_err_i(ape),
        .data_parity_err_i(dpe), .master_abort_i(mab), .target_abort_rcvd_i(tar), .target_abort_sent_i(tas),
        .perr_seen_i(pseen), .master_phase_i(mph), .serr_assert_o(serr_assert_o), .perr_assert_o(perr_assert_o),
        .io_space_enable_o(io_en), .mem_space_enable_o(mem_en), .bus_master_enable_o(mst_en),
        .write_invalidate_enable_o(winv_en), .parity_response_enable_o(par_en),
        .system_error_driver_enable_o(syserr_drv));

    // ************************************************************
    // compare, bus and model helpers
    // ************************************************************
    task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        chk_reg({31'h0, exp}, {31'h0, got});
    endtask

    task automatic cfg_write(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] wd);
        @(posedge ref_clk_i);
        cfg_sel_i <= 1'b1;
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= ad;
        cfg_be_i <= b;
        cfg_wdata_i <= wd;
        @(posedge ref_clk_i);
        cfg_sel_i <= 1'b0;
        cfg_wr_i <= 1'b0;
    endtask

    // answer is looked at in its single valid cycle
    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge ref_clk_i);
        cfg_sel_i <= 1'b1;
        cfg_rd_i <= 1'b1;
        cfg_addr_i <= ad;
        @(posedge ref_clk_i);
        cfg_sel_i <= 1'b0;
        cfg_rd_i <= 1'b0;
        #1;
        chk_bit(1'b1, cfg_rvalid_o);
        chk_reg(exp, cfg_rdata_o);
    endtask

    task automatic fire_evt(input logic [2:0] k);
        @(posedge ref_clk_i);
        fire <= 1'b1;
        kind <= k;
        @(posedge ref_clk_i);
        fire <= 1'b0;
        #1;
    endtask

    function automatic logic [15:0] wr_cmd(input logic [15:0] c, input logic [3:0] b, input logic [31:0] wd);
        if (b[0]) c[7:0] = wd[7:0];
        if (b[1]) c[15:8] = wd[15:8];
        return c & 16'h0157;
    endfunction

    function automatic logic [31:0] exp_word(input logic [7:0] ad);
        return (ad[7:2] == 6'h01) ? {st_m | 16'h0210, cmd_m} : 32'h0;
    endfunction

    function automatic logic [15:0] ev_exp(input int k, input logic [15:0] c);
        case (k)
            0: return c[8] ? 16'hc000 : 16'h8000;
            1: return 16'h8000;
            2: return 16'h2000;
            3: return 16'h1000;
            4: return 16'h0800;
            5: return c[6] ? 16'h0100 : 16'h0000;
            default: return 16'h0000;
        endcase
    endfunction

    task automatic test_done;
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ************************************************************
    // watchdog: the sequence needs a few hundred cycles
    // ************************************************************
    initial begin
        #200_000;
        errors++;
        test_done;
    end

    initial begin
        {resetn_i, cfg_sel_i, cfg_wr_i, cfg_rd_i, fire, io_hit_i, mem_hit_i, special_cycle_i, master_req_i} = 9'h0;
        ce_i = 1'b1;
        kind = 3'h0;
        cfg_addr_i = 8'h00;
        cfg_be_i = 4'h0;
        cfg_wdata_i = 32'h0;
        cmd_m = 16'h0;
        st_m = 16'h0;
        repeat (10) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        rd_chk(8'h04, 32'h0210_0000);
        chk_reg({28'h0, 4'h7}, {28'h0, master_cmd_o});
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            d = (i == 0) ? 32'hffff_ffff : $random(seed);
            be = (i == 0) ? 4'hf : r[11:8];
            a = (r[1:0] == 2'h0) ? {r[7:2], 2'h0} : 8'h04;
            cfg_write(a, be, d);
            if (a[7:2] == 6'h01) cmd_m = wr_cmd(cmd_m, be, d);
            rd_chk(a, exp_word(a));
            chk_reg({26'h0, cmd_m[8], cmd_m[6], cmd_m[4], cmd_m[2:0]},
                {26'h0, syserr_drv, par_en, winv_en, mst_en, mem_en, io_en});
            @(posedge ref_clk_i);
            io_hit_i <= r[12];
            mem_hit_i <= r[13];
            special_cycle_i <= r[14];
            master_req_i <= r[15];
            #1;
            chk_bit(~r[14] & ((r[12] & cmd_m[0]) | (r[13] & cmd_m[1])), target_claim_o);
            chk_bit(r[15] & cmd_m[2], master_req_o);
            chk_reg({28'h0, cmd_m[4] ? 4'hf : 4'h7}, {28'h0, master_cmd_o});
            chk_reg({30'h0, 2'h1}, {30'h0, devsel_timing_o});
        end
        // every event kind, with error reporting enabled and then disabled
        for (int p = 0; p < 2; p++) begin
            cmd_m = (p == 0) ? 16'h0157 : 16'h0000;
            cfg_write(8'h04, 4'h3, {16'h0, cmd_m});
            for (int k = 0; k < 7; k++) begin
                fire_evt(k[2:0]);
                chk_bit(k == 0 && cmd_m[8], serr_assert_o);
                chk_bit(k == 1 && cmd_m[6], perr_assert_o);
                st_m = ev_exp(k, cmd_m);
                rd_chk(8'h04, exp_word(8'h04));
                rd_chk(8'h04, exp_word(8'h04));
                cfg_write(8'h04, 4'hc, 32'h0000_0000);
                rd_chk(8'h04, exp_word(8'h04));
                cfg_write(8'h04, 4'hc, 32'hffff_0000);
                st_m = 16'h0;
                rd_chk(8'h04, exp_word(8'h04));
            end
        end
        // event and clearing write land on the same edge: the event is kept
        @(posedge ref_clk_i);
        fire <= 1'b1;
        kind <= 3'h2;
        cfg_sel_i <= 1'b1;
        cfg_wr_i <= 1'b1;
        cfg_addr_i <= 8'h04;
        cfg_be_i <= 4'hc;
        cfg_wdata_i <= 32'hffff_0000;
        @(posedge ref_clk_i);
        fire <= 1'b0;
        cfg_sel_i <= 1'b0;
        cfg_wr_i <= 1'b0;
        st_m = 16'h2000;
        rd_chk(8'h04, exp_word(8'h04));
        // a write while the clock enable is low must not land
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        cfg_write(8'h04, 4'h3, 32'h0000_0157);
        @(posedge ref_clk_i);
        ce_i <= 1'b1;
        rd_chk(8'h04, exp_word(8'h04));
        cfg_write(8'h04, 4'h3, 32'h0000_0157);
        cmd_m = 16'h0157;
        rd_chk(8'h04, exp_word(8'h04));
        // reset in mid-run clears enables and events, keeps fixed bits
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        #1;
        chk_reg(32'h0, {26'h0, syserr_drv, par_en, winv_en, mst_en, mem_en, io_en});
        rd_chk(8'h04, 32'h0210_0000);
        test_done;
    end
endmodule

// file: verilog/pcfs_cmd_status.sv
`timescale 1ns/10ps
// Summary of operation
// - command bits 15..10 ignore writes and read zero
// - back-to-back master enable, command bit 9, reads zero
// - bit 8 read/write; when set, system error drives on address parity error
// - stepping control, command bit 7, hardwired zero
// - bit 6 read/write; parity error response driven only while set
// - palette snoop enable, command bit 5, reads zero
// - bit 4 selects write-and-invalidate, else plain memory write
// - special cycle enable reads zero; special cycles never claimed
// - bit 2 read/write; mastering allowed only while set
// - bit 1 read/write; memory cycles claimed only while set
// - bit 0 read/write; I/O cycles claimed only while set
// - status events clear on written one, zero no effect, reads harmless
// - status 15 sets on address or data parity error
// - status 14 sets when enabled system error actually signalled
// - status 13 sets on master abort of own master cycle
// - status 12 sets on target abort received as master
// - status 11 sets when target ends transaction with target abort
// - status 10..9 fixed 01, medium decode timing used
// - status 8 sets on parity error seen as master with response enabled
// - status 7, 6, 5 hardwired zero
// - status 4 always reads one, capability list present
// - status 3..0 reserved, read zero
module pcfs_cmd_status (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic cfg_sel_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic io_hit_i,
    input wire logic mem_hit_i,
    input wire logic special_cycle_i,
    output logic target_claim_o,
    output logic [1:0] devsel_timing_o,
    input wire logic master_req_i,
    output logic master_req_o,
    output logic [3:0] master_cmd_o,
    input wire logic addr_parity_err_i,
    input wire logic data_parity_err_i,
    input wire logic master_abort_i,
    input wire logic target_abort_rcvd_i,
    input wire logic target_abort_sent_i,
    input wire logic perr_seen_i,
    input wire logic master_phase_i,
    output logic serr_assert_o,
    output logic perr_assert_o,
    output logic io_space_enable_o,
    output logic mem_space_enable_o,
    output logic bus_master_enable_o,
    output logic write_invalidate_enable_o,
    output logic parity_response_enable_o,
    output logic system_error_driver_enable_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] status_word(input logic [pcfs_pkg::NUM_EVT-1:0] s);
        logic [15:0] w;
        w = 16'h0000;
        w[pcfs_pkg::ST_PAR] = s[pcfs_pkg::EV_PAR];
        w[pcfs_pkg::ST_SYS] = s[pcfs_pkg::EV_SYS];
        w[pcfs_pkg::ST_MAB] = s[pcfs_pkg::EV_MAB];
        w[pcfs_pkg::ST_TAR] = s[pcfs_pkg::EV_TAR];
        w[pcfs_pkg::ST_TAS] = s[pcfs_pkg::EV_TAS];
        w[pcfs_pkg::ST_DEVSEL +: 2] = pcfs_pkg::DEVSEL_MEDIUM;
        w[pcfs_pkg::ST_DPE] = s[pcfs_pkg::EV_DPE];
        w[pcfs_pkg::ST_CAP] = pcfs_pkg::CAP_LIST_PRESENT;
        return w;
    endfunction

    // byte lane of a bit inside the status half-word
    function automatic logic lane_on(input logic [3:0] be, input int bitpos);
        return be[(pcfs_pkg::STAT_LSB + bitpos) / 8];
    endfunction

    // ************************************************************
    // config access decode
    // ************************************************************
    logic cfg_hit;
    logic cmd_wr;
    logic stat_wr;
    logic [15:0] cmd_wdata;
    logic [15:0] cmd_wmask;
    logic [15:0] stat_wdata;

    assign cfg_hit = cfg_sel_i && (cfg_addr_i[7:2] == pcfs_pkg::CFG_CMD_OFF[7:2]);
    assign cmd_wr = cfg_hit && cfg_wr_i;
    assign stat_wr = cmd_wr;
    assign cmd_wdata = cfg_wdata_i[15:0];
    assign stat_wdata = cfg_wdata_i[pcfs_pkg::STAT_LSB +: 16];
    // only documented writable bits take a write
    assign cmd_wmask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}} & pcfs_pkg::CMD_RW_MASK;

    // ************************************************************
    // command register
    // ************************************************************
    logic [15:0] cmd_r;
    logic [15:0] cmd_nxt;

    assign cmd_nxt = (cmd_r & ~cmd_wmask) | (cmd_wdata & cmd_wmask);

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cmd_r <= pcfs_pkg::CMD_RESET;
        end else if (ce_i && cmd_wr) begin
            cmd_r <= cmd_nxt;
        end
    end

    assign io_space_enable_o = cmd_r[pcfs_pkg::CMD_IO];
    assign mem_space_enable_o = cmd_r[pcfs_pkg::CMD_MEM];
    assign bus_master_enable_o = cmd_r[pcfs_pkg::CMD_MAST];
    assign write_invalidate_enable_o = cmd_r[pcfs_pkg::CMD_MWI];
    assign parity_response_enable_o = cmd_r[pcfs_pkg::CMD_PERR];
    assign system_error_driver_enable_o = cmd_r[pcfs_pkg::CMD_SERR];

    // ************************************************************
    // target and master gating
    // ************************************************************
    // special cycles are broadcast; never claim them
    assign target_claim_o = !special_cycle_i &&
        ((io_hit_i && io_space_enable_o) ||
         (mem_hit_i && mem_space_enable_o));
    assign devsel_timing_o = pcfs_pkg::DEVSEL_MEDIUM;
    assign master_req_o = master_req_i && bus_master_enable_o;

    logic [3:0] master_cmd_r;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            master_cmd_r <= pcfs_pkg::BUS_CMD_MEM_WRITE;
        end else if (ce_i) begin
            master_cmd_r <= cmd_nxt[pcfs_pkg::CMD_MWI] && cmd_wr ? pcfs_pkg::BUS_CMD_MWI :
                (cmd_wr ? pcfs_pkg::BUS_CMD_MEM_WRITE :
                 (write_invalidate_enable_o ? pcfs_pkg::BUS_CMD_MWI : pcfs_pkg::BUS_CMD_MEM_WRITE));
        end
    end

    assign master_cmd_o = master_cmd_r;

    // ************************************************************
    // error signalling
    // ************************************************************
    logic serr_r;
    logic perr_r;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            serr_r <= 1'b0;
        end else if (ce_i) begin
            serr_r <= addr_parity_err_i && system_error_driver_enable_o;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            perr_r <= 1'b0;
        end else if (ce_i) begin
            perr_r <= data_parity_err_i && parity_response_enable_o;
        end
    end

    assign serr_assert_o = serr_r;
    assign perr_assert_o = perr_r;

    // ************************************************************
    // status events
    // ************************************************************
    pcfs_stat_if st_bus ();

    always_comb begin
        st_bus.set_evt = '0;
        st_bus.set_evt[pcfs_pkg::EV_PAR] = addr_parity_err_i || data_parity_err_i;
        // only a system error really driven counts
        st_bus.set_evt[pcfs_pkg::EV_SYS] = serr_r;
        st_bus.set_evt[pcfs_pkg::EV_MAB] = master_abort_i;
        st_bus.set_evt[pcfs_pkg::EV_TAR] = target_abort_rcvd_i;
        st_bus.set_evt[pcfs_pkg::EV_TAS] = target_abort_sent_i;
        st_bus.set_evt[pcfs_pkg::EV_DPE] = perr_seen_i && master_phase_i && parity_response_enable_o;
    end

    always_comb begin
        st_bus.clr_evt = '0;
        if (stat_wr) begin
            st_bus.clr_evt[pcfs_pkg::EV_PAR] = stat_wdata[pcfs_pkg::ST_PAR] && lane_on(cfg_be_i, pcfs_pkg::ST_PAR);
            st_bus.clr_evt[pcfs_pkg::EV_SYS] = stat_wdata[pcfs_pkg::ST_SYS] && lane_on(cfg_be_i, pcfs_pkg::ST_SYS);
            st_bus.clr_evt[pcfs_pkg::EV_MAB] = stat_wdata[pcfs_pkg::ST_MAB] && lane_on(cfg_be_i, pcfs_pkg::ST_MAB);
            st_bus.clr_evt[pcfs_pkg::EV_TAR] = stat_wdata[pcfs_pkg::ST_TAR] && lane_on(cfg_be_i, pcfs_pkg::ST_TAR);
            st_bus.clr_evt[pcfs_pkg::EV_TAS] = stat_wdata[pcfs_pkg::ST_TAS] && lane_on(cfg_be_i, pcfs_pkg::ST_TAS);
            st_bus.clr_evt[pcfs_pkg::EV_DPE] = stat_wdata[pcfs_pkg::ST_DPE] && lane_on(cfg_be_i, pcfs_pkg::ST_DPE);
        end
    end

    pcfs_status_bits u_status (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .st(st_bus)
    );

    // ************************************************************
    // config read
    // ************************************************************
    logic [31:0] rdata_r;
    logic rvalid_r;
    logic rd_hit_r;

    // reads only sample; nothing is cleared on read
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rdata_r <= 32'h0000_0000;
            rvalid_r <= 1'b0;
            rd_hit_r <= 1'b0;
        end else if (ce_i) begin
            rvalid_r <= cfg_sel_i && cfg_rd_i;
            rd_hit_r <= cfg_hit && cfg_rd_i;
            // other dwords of the header live elsewhere and read zero here
            rdata_r <= (cfg_hit && cfg_rd_i) ?
                {status_word(st_bus.sticky), cmd_r} : 32'h0000_0000;
        end
    end

    assign cfg_rdata_o = rdata_r;
    assign cfg_rvalid_o = rvalid_r;

    // ************************************************************
    // checks
    // ************************************************************
    property p_cmd_rsvd;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        cfg_rvalid_o |-> (cfg_rdata_o[15:9] == 7'h00 && cfg_rdata_o[7] == 1'b0 &&
            cfg_rdata_o[5] == 1'b0 && cfg_rdata_o[3] == 1'b0);
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd) else $error("fixed command bit not zero");

    property p_serr_drive;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && addr_parity_err_i && system_error_driver_enable_o) |=> serr_assert_o
            ##1 (!$past(ce_i) || st_bus.sticky[pcfs_pkg::EV_SYS]);
    endproperty
    a_serr_drive: assert property (p_serr_drive) else $error("system error not driven or logged");

    property p_perr_gate;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && !parity_response_enable_o) |=> !perr_assert_o;
    endproperty
    a_perr_gate: assert property (p_perr_gate) else $error("parity response while disabled");

    property p_perr_drive;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && data_parity_err_i && parity_response_enable_o) |=> perr_assert_o;
    endproperty
    a_perr_drive: assert property (p_perr_drive) else $error("parity response not driven");

    property p_par_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && (addr_parity_err_i || data_parity_err_i)) |=> st_bus.sticky[pcfs_pkg::EV_PAR];
    endproperty
    a_par_set: assert property (p_par_set) else $error("parity event not logged");

    property p_abort_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && master_abort_i) |=> st_bus.sticky[pcfs_pkg::EV_MAB];
    endproperty
    a_abort_set: assert property (p_abort_set) else $error("master abort not logged");

    property p_plain_write;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && cmd_wr && cfg_be_i[0] && !cfg_wdata_i[pcfs_pkg::CMD_MWI])
            |=> (master_cmd_o == pcfs_pkg::BUS_CMD_MEM_WRITE);
    endproperty
    a_plain_write: assert property (p_plain_write) else $error("invalidate command while disabled");

    property p_master_gate;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        master_req_o |-> bus_master_enable_o && master_req_i;
    endproperty
    a_master_gate: assert property (p_master_gate) else $error("master request while disabled");

    property p_claim;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        target_claim_o |-> !special_cycle_i &&
            ((io_hit_i && io_space_enable_o) || (mem_hit_i && mem_space_enable_o));
    endproperty
    a_claim: assert property (p_claim) else $error("claim without enable");

    property p_dpe_set;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && perr_seen_i && master_phase_i && parity_response_enable_o) |=>
            st_bus.sticky[pcfs_pkg::EV_DPE];
    endproperty
    a_dpe_set: assert property (p_dpe_set) else $error("master parity event not logged");

    property p_fixed_status;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (cfg_rvalid_o && rd_hit_r) |-> (cfg_rdata_o[26:25] == pcfs_pkg::DEVSEL_MEDIUM &&
            cfg_rdata_o[20] == 1'b1 && cfg_rdata_o[23:21] == 3'h0 && cfg_rdata_o[19:16] == 4'h0);
    endproperty
    a_fixed_status: assert property (p_fixed_status) else $error("fixed status field wrong");

    property p_reset_clear;
        @(posedge ref_clk_i)
        !resetn_i |=> (cmd_r == pcfs_pkg::CMD_RESET && st_bus.sticky == pcfs_pkg::EVT_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state set");

endmodule

// file: verilog/pcfs_pkg.sv
package pcfs_pkg;

    // ************************************************************
    // configuration offsets
    // ************************************************************
    localparam logic [7:0] CFG_CMD_OFF = 8'h04;
    localparam logic [7:0] CFG_STAT_OFF = 8'h06;
    localparam int STAT_LSB = 8 * int'(CFG_STAT_OFF[1:0]);

    // ************************************************************
    // command bit positions
    // ************************************************************
    localparam int CMD_IO = 0;
    localparam int CMD_MEM = 1;
    localparam int CMD_MAST = 2;
    localparam int CMD_MWI = 4;
    localparam int CMD_PERR = 6;
    localparam int CMD_SERR = 8;
    localparam logic [15:0] CMD_RW_MASK = 16'h0157;
    localparam logic [15:0] CMD_RESET = 16'h0000;

    // ************************************************************
    // status bit positions and fixed fields
    // ************************************************************
    localparam int ST_PAR = 15;
    localparam int ST_SYS = 14;
    localparam int ST_MAB = 13;
    localparam int ST_TAR = 12;
    localparam int ST_TAS = 11;
    localparam int ST_DEVSEL = 9;
    localparam int ST_DPE = 8;
    localparam int ST_CAP = 4;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic CAP_LIST_PRESENT = 1'b1;

    // ************************************************************
    // sticky event slots
    // ************************************************************
    localparam int NUM_EVT = 6;
    localparam int EV_DPE = 0;
    localparam int EV_TAS = 1;
    localparam int EV_TAR = 2;
    localparam int EV_MAB = 3;
    localparam int EV_SYS = 4;
    localparam int EV_PAR = 5;
    localparam logic [NUM_EVT-1:0] EVT_RESET = 6'h00;

    // ************************************************************
    // master write commands
    // ************************************************************
    localparam logic [3:0] BUS_CMD_MEM_WRITE = 4'h7;
    localparam logic [3:0] BUS_CMD_MWI = 4'hf;

endpackage

// file: verilog/pcfs_stat_if.sv
`timescale 1ns/10ps
interface pcfs_stat_if;
    logic [pcfs_pkg::NUM_EVT-1:0] set_evt;
    logic [pcfs_pkg::NUM_EVT-1:0] clr_evt;
    logic [pcfs_pkg::NUM_EVT-1:0] sticky;
    modport reg_side (input set_evt, input clr_evt, output sticky);
    modport ctl_side (output set_evt, output clr_evt, input sticky);
endinterface

// file: verilog/pcfs_status_bits.sv
`timescale 1ns/10ps
module pcfs_status_bits (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    pcfs_stat_if.reg_side st
);

    logic [pcfs_pkg::NUM_EVT-1:0] sticky_r;
    logic [pcfs_pkg::NUM_EVT-1:0] sticky_nxt;

    // ************************************************************
    // sticky write-one-to-clear events
    // ************************************************************
    // set beats clear so an event in the clearing cycle survives
    assign sticky_nxt = (sticky_r & ~st.clr_evt) | st.set_evt;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sticky_r <= pcfs_pkg::EVT_RESET;
        end else if (ce_i) begin
            sticky_r <= sticky_nxt;
        end
    end

    assign st.sticky = sticky_r;

    // ************************************************************
    // checks
    // ************************************************************
    property p_set_wins;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && (st.set_evt != '0)) |=> ((st.sticky & $past(st.set_evt)) == $past(st.set_evt));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost in clear cycle");

    property p_w1c;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && (st.clr_evt != '0) && ((st.clr_evt & st.set_evt) == '0))
            |=> ((st.sticky & $past(st.clr_evt)) == '0);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear");

endmodule
